// ---- bench/tsm_checker.sv ----
// link checker for the table engine and its instruction sequencer
`timescale 1ns/1ps
module tsm_checker import tsm_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire tsm_op_e req_op,
  input wire logic [LEN_W-1:0] req_len,
  input wire logic [WORD_W-1:0] req_acc,
  input wire logic [WORD_W-1:0] req_arg,
  input wire logic scan_end,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire tsm_rsp_s rsp,
  input wire logic search_miss_flag,
  input wire logic pointer_limit_flag
);
  tsm_op_e last_op; // last instruction the engine took
  logic took_seen; // a take happened since reset

  // flag changes are traced back to the instruction that was taken
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      last_op <= mem_read_op;
      took_seen <= 1'b0;
    end else if (req_valid && req_ready) begin
      last_op <= req_op;
      took_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    rsp_valid;
  endsequence

  a_req_hold: assert property (req_valid && !req_ready
    |=> req_valid && $stable(req_op) && $stable(req_len) &&
    $stable(req_acc) && $stable(req_arg))
    else $error("request changed before it was taken");
  a_take_gap: assert property (s_take |=> !req_ready [*2])
    else $error("engine took a second request too early");
  a_ready_answer: assert property ($rose(req_ready) && took_seen
    |-> s_answer) else $error("engine ready again without an answer");
  a_answer_bound: assert property (s_take |-> ##[1:600] s_answer)
    else $error("no answer after a taken request");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready
    |=> rsp_valid && $stable(rsp)) else $error("answer lost in a stall");
  a_miss_source: assert property ($changed(search_miss_flag)
    |-> last_op == find_greater_op) else $error("miss flag moved");
  a_limit_source: assert property ($rose(pointer_limit_flag)
    |-> last_op inside {table_to_dest_op, remove_bottom_op})
    else $error("limit flag set by a non-move");
  a_limit_clear: assert property ($fell(pointer_limit_flag)
    |-> $past(scan_end) || last_op inside {table_to_dest_op,
    remove_bottom_op}) else $error("limit flag cleared without cause");
  a_scan_pulse: assert property (scan_end |=> !scan_end)
    else $error("scan end longer than one cycle");
endmodule : tsm_checker

// ---- bench/tsm_tb_top.sv ----
// self-checking bench: sequencer and engine joined over the link
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end
module tsm_tb_top import tsm_pkg::*; ();
  logic CLOCK, RST_N; // bench clock and reset
  logic cmd_valid, cmd_ready, rung, one_shot, scan_end, res_ready;
  logic res_valid, miss_flag, limit_flag, busy; // design outputs
  tsm_op_e cmd_op; // instruction to issue
  logic [LEN_W-1:0] cmd_len; // table length
  logic [WORD_W-1:0] cmd_addr, cmd_arg; // start address and operand
  tsm_rsp_s res, r; // answer from the design and last captured one
  logic [WORD_W-1:0] p, np, sel; // expected pointer before, after, pick
  logic got; // an answer arrived
  int miscompares = 0;
  int samples_checked = 0;
  logic [WORD_W-1:0] srch [5][4]; // arg, len, offset, miss per search

  tsm_link_if i_tsm_link_if (.CLOCK(CLOCK), .RST_N(RST_N));
  tsm_engine i_tsm_engine (.CLOCK(CLOCK), .RST_N(RST_N),
    .link(i_tsm_link_if), .SEARCH_MISS_FLAG(miss_flag),
    .POINTER_LIMIT_FLAG(limit_flag), .BUSY(busy));
  tsm_sequencer i_tsm_sequencer (.CLOCK(CLOCK), .RST_N(RST_N),
    .link(i_tsm_link_if), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OP(cmd_op), .CMD_LEN(cmd_len), .CMD_ADDR(cmd_addr),
    .CMD_ARG(cmd_arg), .RUNG(rung), .ONE_SHOT(one_shot),
    .SCAN_END(scan_end), .RES_READY(res_ready), .RES_VALID(res_valid),
    .RES(res));
  tsm_checker i_tsm_checker (.CLOCK(CLOCK), .RST_N(RST_N),
    .req_valid(i_tsm_link_if.req_valid), .req_op(i_tsm_link_if.req_op),
    .req_ready(i_tsm_link_if.req_ready), .req_len(i_tsm_link_if.req_len),
    .req_acc(i_tsm_link_if.req_acc), .req_arg(i_tsm_link_if.req_arg),
    .scan_end(i_tsm_link_if.scan_end), .rsp(i_tsm_link_if.rsp),
    .rsp_valid(i_tsm_link_if.rsp_valid),
    .rsp_ready(i_tsm_link_if.rsp_ready),
    .search_miss_flag(i_tsm_link_if.search_miss_flag),
    .pointer_limit_flag(i_tsm_link_if.pointer_limit_flag));

  // 200 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  // verdict and end of run, shared by the tests and the watchdog
  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // offer one instruction; held until the take edge
  task automatic send(input tsm_op_e op, input logic [LEN_W-1:0] len,
      input logic [WORD_W-1:0] addr, input logic [WORD_W-1:0] arg);
    int n;
    n = 0;
    @(posedge CLOCK);
    cmd_op <= op;
    cmd_len <= len;
    cmd_addr <= addr;
    cmd_arg <= arg;
    cmd_valid <= 1'b1;
    do @(negedge CLOCK); while (cmd_ready !== 1'b1 && ++n < 200);
    @(posedge CLOCK);
    cmd_valid <= 1'b0;
  endtask : send

  // wait a bounded time for the one-cycle answer pulse
  task automatic recv(output tsm_rsp_s a, output logic ok);
    int n;
    n = 0;
    do @(negedge CLOCK); while (res_valid !== 1'b1 && ++n < 800);
    ok = (res_valid === 1'b1);
    a = res;
  endtask : recv

  // full instruction: issue and demand an answer
  task automatic op(input tsm_op_e o, input logic [LEN_W-1:0] len,
      input logic [WORD_W-1:0] addr, input logic [WORD_W-1:0] arg);
    send(o, len, addr, arg);
    recv(r, got);
    `CHK(got, 1'b1)
  endtask : op

  task automatic wr(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] d);
    op(mem_write_op, IDX_RESET, a, d);
  endtask : wr

  task automatic expect_mem(input logic [WORD_W-1:0] a,
      input logic [WORD_W-1:0] e);
    op(mem_read_op, IDX_RESET, a, 16'h0000);
    `CHK(r.acc, e)
  endtask : expect_mem

  // a hang counts as a mismatch and ends the run
  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  // main test sequence
  initial begin
    cmd_valid = 1'b0;
    cmd_op = mem_read_op;
    cmd_len = '0;
    cmd_addr = '0;
    cmd_arg = '0;
    rung = 1'b1;
    one_shot = 1'b0;
    scan_end = 1'b0;
    res_ready = 1'b1;
    RST_N = 1'b0;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(negedge CLOCK);
    `CHK(miss_flag, FLAG_RESET)
    `CHK(limit_flag, FLAG_RESET)
    `CHK(busy, 1'b0)
    expect_mem(16'h0010, 16'h0000);
    // search table 0005 0003 8000 0009: equal is not greater, unsigned
    wr(16'h0010, 16'h0005);
    wr(16'h0011, 16'h0003);
    wr(16'h0012, 16'h8000);
    wr(16'h0013, 16'h0009);
    srch = '{'{16'h0005, 16'h4, 16'h2, 16'h0}, '{16'h0004, 16'h4, 16'h0,
      16'h0}, '{16'h0000, 16'h0, 16'h0, 16'h1}, '{16'h0009, 16'h3, 16'h2,
      16'h0}, '{16'h8000, 16'h4, 16'h0, 16'h1}};
    for (int i = 0; i < 5; i++) begin
      op(find_greater_op, srch[i][1][7:0], 16'h0010, srch[i][0]);
      `CHK(r.acc, srch[i][2])
      `CHK(r.miss, srch[i][3][0])
      `CHK(miss_flag, srch[i][3][0])
    end
    // forward moves over a three-word table, pointer from zero
    wr(16'h0040, 16'h0000);
    for (int i = 1; i <= 3; i++) wr(16'h0040 + 16'(i), 16'h00A0 + 16'(i));
    p = 16'h0000;
    for (int k = 0; k < 5; k++) begin
      sel = (p == 16'h0000 || p == 16'h0003) ? 16'h0001 : p;
      np = (p == 16'h0003) ? PTR_WRAP : p + PTR_STEP;
      op(table_to_dest_op, 8'h03, 16'h0040, 16'h0080);
      `CHK(r.acc, np)
      `CHK(limit_flag, (np == 16'h0003))
      expect_mem(16'h0080, 16'h00A0 + sel);
      expect_mem(16'h0040, np);
      if (np == 16'h0003) begin
        @(posedge CLOCK);
        scan_end <= 1'b1;
        @(posedge CLOCK);
        scan_end <= 1'b0;
        repeat (3) @(negedge CLOCK);
        `CHK(limit_flag, 1'b0)
        `CHK(miss_flag, 1'b1)
      end
      p = np;
    end
    // moves refused by a low rung and by a steady rung in one-shot mode
    for (int c = 0; c < 2; c++) begin
      @(posedge CLOCK);
      rung <= c[0];
      one_shot <= c[0];
      send(table_to_dest_op, 8'h03, 16'h0040, 16'h0080);
      recv(r, got);
      `CHK(got, 1'b0)
    end
    expect_mem(16'h0040, 16'h0002);
    // a fresh low-to-high rung moves once in one-shot mode
    @(posedge CLOCK);
    rung <= 1'b0;
    @(posedge CLOCK);
    fork
      op(table_to_dest_op, 8'h03, 16'h0040, 16'h0080);
      begin
        @(posedge CLOCK);
        rung <= 1'b1;
      end
    join
    `CHK(r.acc, 16'h0003)
    expect_mem(16'h0080, 16'h00A2);
    @(posedge CLOCK);
    one_shot <= 1'b0;
    // pointer above the length moves nothing
    wr(16'h0040, 16'h0005);
    wr(16'h0080, 16'h5A5A);
    op(table_to_dest_op, 8'h03, 16'h0040, 16'h0080);
    `CHK(r.limit, 1'b0)
    expect_mem(16'h0080, 16'h5A5A);
    // backward moves from a preset pointer down to zero and past it
    wr(16'h0060, 16'h0003);
    for (int i = 1; i <= 3; i++) wr(16'h0060 + 16'(i), 16'h00B0 + 16'(i));
    p = 16'h0003;
    for (int k = 0; k < 4; k++) begin
      if (p == PTR_ZERO) wr(16'h0080, 16'h5A5A);
      np = (p == PTR_ZERO) ? PTR_ZERO : p - PTR_STEP;
      op(remove_bottom_op, 8'h03, 16'h0060, 16'h0080);
      `CHK(r.acc, np)
      `CHK(limit_flag, (np == PTR_ZERO))
      expect_mem(16'h0080,
        (p == PTR_ZERO) ? 16'h5A5A : 16'h00B0 + p);
      p = np;
    end
    // answer buffer fills while the receiver stalls, then drains in order
    @(posedge CLOCK);
    res_ready <= 1'b0;
    for (int i = 0; i < 3; i++)
      send(mem_write_op, 8'h00, 16'h0090, 16'h00C0 + 16'(i));
    repeat (10) @(negedge CLOCK);
    `CHK(i_tsm_link_if.rsp_valid, 1'b1)
    `CHK(i_tsm_link_if.req_ready, 1'b0)
    `CHK(busy, 1'b1)
    @(posedge CLOCK);
    res_ready <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      recv(r, got);
      `CHK(r.acc, 16'h00C0 + 16'(i))
    end
    summarize();
  end
endmodule : tsm_tb_top

// ---- hdl/tsm_answer_buf.sv ----
// small valid/ready buffer that holds answers while the sequencer stalls
`timescale 1ns/1ps
module tsm_answer_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
  localparam int CW = $clog2(DEPTH + 1); // counter width
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1); // last slot index
  localparam logic [CW-1:0] FULL = CW'(DEPTH); // count when full

  logic [WIDTH-1:0] slot [DEPTH]; // storage, one flop row per entry
  logic [PW-1:0] wr_ptr; // next slot to fill
  logic [PW-1:0] rd_ptr; // oldest slot
  logic [CW-1:0] count; // filled slots
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push; // a word enters
  logic pop; // a word leaves

  // full and empty come straight from the counter, no guessing
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and counter update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : PW'(wr_ptr + 1'b1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : PW'(rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage rows; data needs no reset since count guards it
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    logic [WIDTH-1:0] next_slot;
    always_comb begin
      next_slot = slot[i];
      if (push && (wr_ptr == PW'(i))) begin
        next_slot = in_data;
      end
    end
    always_ff @(posedge CLOCK) begin
      slot[i] <= next_slot;
    end
  end
endmodule : tsm_answer_buf

// ---- hdl/tsm_engine.sv ----
// table engine: greater-than search and the two pointer moves
`timescale 1ns/1ps
// Summary of operation
// [R1] search stops at first entry above operand
// [R2] issuer loads length then start address
// [R3] found: accumulator gets offset of entry
// [R4] not found: miss flag set, accumulator zero
// [R5] search offset always starts at zero
// [R6] miss flag held until next search
// [R7] forward move copies entry, pointer plus one
// [R8] pointer zero or length picks word one
// [R9] forward pointer wraps to one, not zero
// [R10] limit flag while pointer equals length
// [R11] limit flag clears at scan end
// [R12] move runs once per enabled scan
// [R13] backward move copies entry, pointer minus one
// [R14] backward move stops at pointer zero
// [R15] backward limit flag when pointer zero
// [R16] backward pointer k picks data word k
// [R17] program presets the backward pointer word
// [R18] moves take length and pointer address
// [R19] issuer may gate enable with one-shot
// [R20] all words are 16-bit unsigned
module tsm_engine import tsm_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  tsm_link_if.dev link,
  output logic SEARCH_MISS_FLAG,
  output logic POINTER_LIMIT_FLAG,
  output logic BUSY
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_EXEC,
    ST_REPLY
  } tsm_state_e;

  tsm_state_e state; // engine sequence
  tsm_state_e next_state;
  tsm_op_e op; // instruction in progress
  tsm_op_e next_op;
  logic [LEN_W-1:0] len; // table length from the stack
  logic [LEN_W-1:0] next_len;
  logic [ADDR_W-1:0] start; // table start, also the pointer word
  logic [ADDR_W-1:0] next_start;
  logic [WORD_W-1:0] arg; // search operand or destination address
  logic [WORD_W-1:0] next_arg;
  logic [LEN_W-1:0] idx; // search offset
  logic [LEN_W-1:0] next_idx;
  tsm_rsp_s res; // answer being assembled
  tsm_rsp_s next_res;
  logic miss; // search miss flag
  logic next_miss;
  logic limit; // pointer status flag
  logic next_limit;
  logic req_ready; // taking instructions
  logic next_req_ready;
  logic busy; // an instruction is running
  logic next_busy;

  logic [WORD_W-1:0] mem [MEM_DEPTH]; // word memory
  logic we_a; // write port a: destination or plain write
  logic [ADDR_W-1:0] wa_a;
  logic [WORD_W-1:0] wd_a;
  logic we_b; // write port b: pointer word
  logic [ADDR_W-1:0] wa_b;
  logic [WORD_W-1:0] wd_b;

  logic [WORD_W-1:0] ptr; // pointer word as stored
  logic [WORD_W-1:0] len_w; // length widened for compares
  logic [WORD_W-1:0] entry; // search entry under idx
  logic [WORD_W-1:0] new_ptr; // pointer after the move
  logic [ADDR_W-1:0] sel; // data word picked by the pointer
  logic buf_ready; // answer buffer has room

  assign ptr = mem[start];
  assign len_w = {{(WORD_W-LEN_W){1'b0}}, len};
  assign entry = mem[ADDR_W'(start + idx)];

  assign link.req_ready = req_ready;
  assign link.search_miss_flag = miss;
  assign link.pointer_limit_flag = limit;
  assign SEARCH_MISS_FLAG = miss;
  assign POINTER_LIMIT_FLAG = limit;
  assign BUSY = busy;

  // sequence: take, search or execute, then hand the answer on
  always_comb begin
    next_state = state;
    next_op = op;
    next_len = len;
    next_start = start;
    next_arg = arg;
    next_idx = idx;
    next_res = res;
    next_miss = miss;
    next_req_ready = req_ready || (state == ST_IDLE); // idle always takes
    next_busy = busy;
    // end of scan clears the limit flag; a set below still wins
    next_limit = link.scan_end ? FLAG_RESET : limit; // [R11]
    we_a = 1'b0;
    wa_a = '0;
    wd_a = '0;
    we_b = 1'b0;
    wa_b = start;
    wd_b = '0;
    new_ptr = ptr;
    sel = FIRST_DATA;
    case (state)
      ST_IDLE: begin
        // each accepted move is one enabled scan's run
        if (link.req_valid && req_ready) begin // [R12]
          next_op = link.req_op;
          next_len = link.req_len; // [R18]
          next_start = link.req_acc[ADDR_W-1:0];
          next_arg = link.req_arg;
          next_idx = IDX_RESET; // [R5]
          next_req_ready = 1'b0;
          next_busy = 1'b1;
          next_state = (link.req_op == find_greater_op) ? ST_SEARCH : ST_EXEC;
        end
      end
      ST_SEARCH: begin
        // unsigned compare, one entry per cycle from offset zero
        if ((len != '0) && (entry > arg)) begin // [R1] [R20]
          next_res.acc = {{(WORD_W-LEN_W){1'b0}}, idx}; // [R3]
          next_res.miss = 1'b0;
          next_miss = 1'b0; // [R6]
          next_res.limit = next_limit;
          next_state = ST_REPLY;
        end else if ((len == '0) || (idx == LEN_W'(len - 1'b1))) begin
          next_res.acc = MISS_ACC; // [R4]
          next_res.miss = 1'b1;
          next_miss = 1'b1; // [R4] [R6]
          next_res.limit = next_limit;
          next_state = ST_REPLY;
        end else begin
          next_idx = LEN_W'(idx + 1'b1);
        end
      end
      ST_EXEC: begin
        next_state = ST_REPLY;
        next_res.acc = ptr;
        next_res.miss = miss;
        case (op)
          table_to_dest_op: begin
            // pointer beyond the length moves nothing
            if (ptr <= len_w) begin
              if ((ptr == PTR_ZERO) || (ptr == len_w)) begin
                sel = FIRST_DATA; // [R8]
              end else begin
                sel = ptr[ADDR_W-1:0]; // [R8]
              end
              new_ptr = (ptr == len_w) ? PTR_WRAP : ptr + PTR_STEP; // [R9]
              we_a = 1'b1; // [R7]
              wa_a = arg[ADDR_W-1:0];
              wd_a = mem[ADDR_W'(start + sel)];
              we_b = 1'b1; // [R7]
              wd_b = new_ptr;
            end
            next_limit = (new_ptr == len_w); // [R10]
          end
          remove_bottom_op: begin
            // the pointer word is taken as the program left it
            if (ptr == PTR_ZERO) begin // [R14] [R17]
              next_limit = 1'b1; // [R15]
            end else if (ptr <= len_w) begin
              sel = ptr[ADDR_W-1:0]; // [R16]
              new_ptr = ptr - PTR_STEP; // [R13]
              we_a = 1'b1; // [R13]
              wa_a = arg[ADDR_W-1:0];
              wd_a = mem[ADDR_W'(start + sel)];
              we_b = 1'b1;
              wd_b = new_ptr;
              next_limit = (new_ptr == PTR_ZERO); // [R15]
            end else begin
              next_limit = 1'b0;
            end
          end
          mem_write_op: begin
            // plain write, used to preset tables and pointers
            we_a = 1'b1;
            wa_a = start;
            wd_a = arg;
            next_res.acc = arg;
          end
          mem_read_op: begin
            next_res.acc = ptr;
          end
          default: begin
            next_res.acc = ACC_RESET;
          end
        endcase
        next_res.acc = (op == table_to_dest_op || op == remove_bottom_op)
          ? new_ptr : next_res.acc;
        next_res.limit = next_limit;
      end
      ST_REPLY: begin
        // the engine stalls here while the buffer is full
        if (buf_ready) begin
          next_state = ST_IDLE;
          next_req_ready = 1'b1;
          next_busy = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_req_ready = 1'b1;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      op <= find_greater_op;
      len <= '0;
      start <= '0;
      arg <= ACC_RESET;
      idx <= IDX_RESET;
      res <= '0;
      miss <= FLAG_RESET;
      limit <= FLAG_RESET;
      req_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      len <= next_len;
      start <= next_start;
      arg <= next_arg;
      idx <= next_idx;
      res <= next_res;
      miss <= next_miss;
      limit <= next_limit;
      req_ready <= next_req_ready;
      busy <= next_busy;
    end
  end

  // word memory rows; port a wins if both ports hit one word
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
    logic [WORD_W-1:0] next_word;
    always_comb begin
      next_word = mem[i];
      if (we_b && (wa_b == ADDR_W'(i))) begin
        next_word = wd_b;
      end
      if (we_a && (wa_a == ADDR_W'(i))) begin
        next_word = wd_a;
      end
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        mem[i] <= ACC_RESET;
      end else begin
        mem[i] <= next_word;
      end
    end
  end

  // answers wait here so a stalled sequencer loses none
  tsm_answer_buf #(.WIDTH(RSP_W), .DEPTH(BUF_DEPTH)) u_buf (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .in_valid(state == ST_REPLY),
    .in_ready(buf_ready),
    .in_data(res),
    .out_valid(link.rsp_valid),
    .out_ready(link.rsp_ready),
    .out_data(link.rsp)
  );
endmodule : tsm_engine

// ---- hdl/tsm_link_if.sv ----
// link between the instruction sequencer and the table engine
`timescale 1ns/1ps
interface tsm_link_if import tsm_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N
);
  logic req_valid; // sequencer offers an instruction
  logic req_ready; // engine takes it
  tsm_op_e req_op; // which instruction
  logic [LEN_W-1:0] req_len; // first stack level: table length
  logic [WORD_W-1:0] req_acc; // accumulator: table start address
  logic [WORD_W-1:0] req_arg; // operand or destination address
  logic scan_end; // one-cycle pulse at the end of every scan
  logic rsp_valid; // answer offered by the engine
  logic rsp_ready; // sequencer takes the answer
  tsm_rsp_s rsp; // answer word
  logic search_miss_flag; // live search miss flag
  logic pointer_limit_flag; // live pointer status flag

  modport dev (
    input CLOCK, RST_N, req_valid, req_op, req_len, req_acc, req_arg,
    input scan_end, rsp_ready,
    output req_ready, rsp_valid, rsp, search_miss_flag, pointer_limit_flag
  );
  modport host (
    input CLOCK, RST_N, req_ready, rsp_valid, rsp,
    input search_miss_flag, pointer_limit_flag,
    output req_valid, req_op, req_len, req_acc, req_arg, scan_end, rsp_ready
  );
endinterface : tsm_link_if

// ---- hdl/tsm_pkg.sv ----
// package with constants, commands and types of the table search and move engine
package tsm_pkg;
  localparam int WORD_W = 16; // every table word is 16 bits, unsigned
  localparam int ADDR_W = 8; // word memory address width
  localparam int MEM_DEPTH = 256; // words of word memory held in flops
  localparam int LEN_W = 8; // table length, 0 to FF
  localparam int BUF_DEPTH = 2; // entries of the answer buffer
  localparam logic [WORD_W-1:0] ACC_RESET = 16'h0000; // accumulator after reset
  localparam logic [WORD_W-1:0] MISS_ACC = 16'h0000; // answer when nothing found
  localparam logic [WORD_W-1:0] PTR_ZERO = 16'h0000; // empty pointer value
  localparam logic [WORD_W-1:0] PTR_WRAP = 16'h0001; // pointer after a wrap
  localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001; // pointer step per run
  localparam logic [ADDR_W-1:0] FIRST_DATA = 8'h01; // first word after pointer
  localparam logic [LEN_W-1:0] IDX_RESET = 8'h00; // search offset starts here
  localparam logic FLAG_RESET = 1'b0; // status flags after reset

  // instructions carried over the link
  typedef enum logic [2:0] {
    find_greater_op,
    table_to_dest_op,
    remove_bottom_op,
    mem_write_op,
    mem_read_op
  } tsm_op_e;

  // one answer word: accumulator and both status flags
  typedef struct packed {
    logic [WORD_W-1:0] acc;
    logic miss;
    logic limit;
  } tsm_rsp_s;

  localparam int RSP_W = WORD_W + 2; // width of one answer word
endpackage : tsm_pkg

// ---- hdl/tsm_sequencer.sv ----
// sequencer end: issues table instructions and collects answers
`timescale 1ns/1ps
module tsm_sequencer import tsm_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  tsm_link_if.host link,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire tsm_op_e CMD_OP,
  input wire logic [LEN_W-1:0] CMD_LEN,
  input wire logic [WORD_W-1:0] CMD_ADDR,
  input wire logic [WORD_W-1:0] CMD_ARG,
  input wire logic RUNG,
  input wire logic ONE_SHOT,
  input wire logic SCAN_END,
  input wire logic RES_READY,
  output logic RES_VALID,
  output tsm_rsp_s RES
);
  logic req_valid; // instruction on the link
  logic next_req_valid;
  tsm_op_e req_op;
  tsm_op_e next_req_op;
  logic [LEN_W-1:0] req_len;
  logic [LEN_W-1:0] next_req_len;
  logic [WORD_W-1:0] req_acc;
  logic [WORD_W-1:0] next_req_acc;
  logic [WORD_W-1:0] req_arg;
  logic [WORD_W-1:0] next_req_arg;
  logic cmd_ready; // room for the next command
  logic next_cmd_ready;
  logic scan_end; // scan end pulse, registered
  logic rsp_ready; // answers may be taken
  logic rung_prev; // last rung level, for the one-shot
  logic res_valid;
  logic next_res_valid;
  tsm_rsp_s res;
  tsm_rsp_s next_res;
  logic is_move; // command is one of the pointer moves
  logic rising_one_shot; // rung went low to high
  logic fire_ok; // command may go out
  logic take; // command accepted

  assign link.req_valid = req_valid;
  assign link.req_op = req_op;
  assign link.req_len = req_len;
  assign link.req_acc = req_acc;
  assign link.req_arg = req_arg;
  assign link.scan_end = scan_end;
  assign link.rsp_ready = rsp_ready;
  assign CMD_READY = cmd_ready;
  assign RES_VALID = res_valid;
  assign RES = res;

  assign is_move = (CMD_OP == table_to_dest_op) ||
                   (CMD_OP == remove_bottom_op);
  assign rising_one_shot = RUNG && !rung_prev; // [R19]
  // a disabled move is dropped, so a level rung moves once per scan
  assign fire_ok = !is_move || (ONE_SHOT ? rising_one_shot : RUNG); // [R12]
  assign take = CMD_VALID && cmd_ready;

  // command hand-off and answer capture
  always_comb begin
    next_req_valid = req_valid;
    next_req_op = req_op;
    next_req_len = req_len;
    next_req_acc = req_acc;
    next_req_arg = req_arg;
    next_res_valid = 1'b0;
    next_res = res;
    if (req_valid && link.req_ready) begin
      next_req_valid = 1'b0;
    end
    if (take && fire_ok) begin
      next_req_valid = 1'b1;
      next_req_op = CMD_OP;
      next_req_len = CMD_LEN; // [R2] [R18]
      next_req_acc = CMD_ADDR; // [R2] [R18]
      next_req_arg = CMD_ARG;
    end
    next_cmd_ready = !next_req_valid;
    if (link.rsp_valid && rsp_ready) begin
      next_res_valid = 1'b1;
      next_res = link.rsp;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      req_valid <= 1'b0;
      req_op <= find_greater_op;
      req_len <= '0;
      req_acc <= ACC_RESET;
      req_arg <= ACC_RESET;
      cmd_ready <= 1'b0;
      scan_end <= 1'b0;
      rsp_ready <= 1'b0;
      rung_prev <= 1'b0;
      res_valid <= 1'b0;
      res <= '0;
    end else begin
      req_valid <= next_req_valid;
      req_op <= next_req_op;
      req_len <= next_req_len;
      req_acc <= next_req_acc;
      req_arg <= next_req_arg;
      cmd_ready <= next_cmd_ready;
      scan_end <= SCAN_END;
      rsp_ready <= RES_READY;
      rung_prev <= RUNG;
      res_valid <= next_res_valid;
      res <= next_res;
    end
  end
endmodule : tsm_sequencer
